// ==== logic/node_cfg_decode.sv ====
/*
 * Combinational resolver: splits switches into address and rate code and
 * falls back to stored values for zero fields.
 * Assumes switch bits are 1 when closed and stored values are stable.
 */
`timescale 1ns/100ps
module node_cfg_decode
   import node_cfg_pkg::*;
(
   input  wire logic [SW_W-1:0]   sw_bits,
   input  wire logic [ADDR_W-1:0] nvm_addr,
   input  wire logic [RATE_W-1:0] nvm_rate,
   node_cfg_if.dec                cfg
);
   logic [ADDR_W-1:0] sw_addr;
   logic [RATE_W-1:0] sw_rate;

   // field split and zero fallback
   always_comb begin
      sw_addr = sw_bits[ADDR_LSB +: ADDR_W];  // RL1
      sw_rate = sw_bits[RATE_LSB +: RATE_W];  // RL2
      cfg.addr = (sw_addr == ADDR_FROM_NVM) ? nvm_addr : sw_addr;  // RL4
      cfg.rate = (sw_rate == RATE_FROM_NVM) ? nvm_rate : sw_rate;  // RL5
      case (rate_code_t'(cfg.rate))  // RL6
         RATE_9K6:   cfg.rate_div = DIV_9K6;
         RATE_38K4:  cfg.rate_div = DIV_38K4;
         RATE_115K2: cfg.rate_div = DIV_115K2;
         default:    cfg.rate_div = DIV_9K6;  // stored zero: slowest rate
      endcase
   end
endmodule

// ==== logic/node_cfg_if.sv ====
/*
 * Carries the resolved settings from the decoder to the capture sequencer.
 * Assumes both ends sit in the same clock domain.
 */
`timescale 1ns/100ps
interface node_cfg_if;
   import node_cfg_pkg::*;
   logic [ADDR_W-1:0] addr;
   logic [RATE_W-1:0] rate;
   logic [16:0]       rate_div;
   modport dec (output addr, output rate, output rate_div);
   modport use_side (input addr, input rate, input rate_div);
endinterface

// ==== logic/node_cfg_pkg.sv ====
/*
 * Constants and types shared by the serial node configuration selector.
 * Assumes a single 200 MHz clock domain and an asynchronous active-low reset.
 */
package node_cfg_pkg;
   localparam int unsigned ADDR_W      = 6;
   localparam int unsigned RATE_W      = 2;
   localparam int unsigned SW_W        = 8;
   localparam int unsigned ADDR_LSB    = 0;  // switch 1 position
   localparam int unsigned RATE_LSB    = 6;  // switch 7 position
   localparam int unsigned SETTLE_W    = 8;
   localparam int unsigned CLK_MHZ     = 200;
   // switch settle time after reset release, in ns
   localparam int unsigned SETTLE_NS   = 1000;
   localparam int unsigned SETTLE_CYC  = (SETTLE_NS * CLK_MHZ) / 1000;

   localparam logic [ADDR_W-1:0] ADDR_FROM_NVM = 6'h00;
   localparam logic [RATE_W-1:0] RATE_FROM_NVM = 2'h0;

   // bit rate selections seen by the rs-485 serial engine
   typedef enum logic [1:0] {
      RATE_NVM   = 2'h0,
      RATE_9K6   = 2'h1,
      RATE_38K4  = 2'h2,
      RATE_115K2 = 2'h3
   } rate_code_t;

   // bit rates in bits per second, used for divider sizing downstream
   localparam int unsigned BPS_9K6   = 9600;
   localparam int unsigned BPS_38K4  = 38400;
   localparam int unsigned BPS_115K2 = 115200;
   localparam logic [16:0] DIV_9K6   = 17'((CLK_MHZ * 1000000) / BPS_9K6);
   localparam logic [16:0] DIV_38K4  = 17'((CLK_MHZ * 1000000) / BPS_38K4);
   localparam logic [16:0] DIV_115K2 = 17'((CLK_MHZ * 1000000) / BPS_115K2);
endpackage

// ==== logic/serial_node_config_select.sv ====
/*
 * Top of the serial node configuration selector: samples eight switches once
 * after reset, resolves node address and bit rate, selects port personality.
 * Holds the capture sequencer, the captured configuration registers and the
 * registered rs-485/rs-232 personality stage; field split and stored-value
 * fallback sit in the decoder instantiated here.
 * Assumes switches, stored values and the select pin are synchronous to clk,
 * and that stored values are settled by the capture edge.
 * Switch moves count only after the next reset; the rs-232 divider comes
 * from elsewhere and is only passed through.
 */
// How it works
// RL1: switches one to six form address, switch one least significant.
// RL2: switch seven is rate bit zero, switch eight rate bit one.
// RL3: rs-232 settings never depend on the eight switches.
// RL4: zero switch address means use the stored address.
// RL5: zero switch rate code means use the stored rate.
// RL6: rate codes 1, 2, 3 mean 9.6, 38.4, 115.2 kbps.
// RL7: select pin low gives rs-485 mode, otherwise rs-232 mode.
// RL8: switches sampled after reset release, result held until next reset.
`timescale 1ns/100ps
module serial_node_config_select
   import node_cfg_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = SETTLE_CYC
)(
   input  wire logic                clk,
   input  wire logic                rst_n,
   input  wire logic [SW_W-1:0]     sw_bits,
   input  wire logic [ADDR_W-1:0]   nvm_addr,
   input  wire logic [RATE_W-1:0]   nvm_rate,
   input  wire logic                sel_pin,
   input  wire logic [16:0]         rs232_div_in,
   output logic                     cfg_valid,
   output logic [ADDR_W-1:0]        node_addr,
   output logic [RATE_W-1:0]        rate_code,
   output logic [16:0]              rate_div,
   output logic                     rs485_mode,
   output logic [16:0]              active_div
);
   // capture sequencer states: settle, sample once, hold
   typedef enum logic [1:0] {
      S_SETTLE,
      S_CAPTURE,
      S_HOLD
   } cap_state_t;

   // elaboration checks: refuse settings the logic cannot serve
   // settle counter must reach its last value within SETTLE_W bits
   if (SETTLE_CYCLES < 1 || SETTLE_CYCLES >= (1 << SETTLE_W)) begin
      $error("settle count out of range");
   end

   // the two switch fields together must use the whole bank
   if (ADDR_W + RATE_W != SW_W) begin
      $error("switch fields do not cover the switch bank");
   end

   // rate field sits directly above the address field
   if (ADDR_LSB + ADDR_W != RATE_LSB) begin
      $error("rate field must follow the address field");
   end

   // rate field and rate code type must agree in width
   if (RATE_W != $bits(rate_code_t)) begin
      $error("rate field width differs from the rate code type");
   end

   // fallback keys on an all-zero field
   if (ADDR_FROM_NVM != '0 || RATE_FROM_NVM != '0) begin
      $error("stored-value markers must be zero");
   end

   // slowest rate must not wrap the 17-bit divider path
   if ((CLK_MHZ * 1000000) / BPS_9K6 != int'(DIV_9K6)) begin
      $error("slowest divider does not fit the divider path");
   end

   // fastest rate needs at least one clock per bit
   if ((CLK_MHZ * 1000000) / BPS_115K2 < 1) begin
      $error("clock too slow for the fastest rate");
   end

   // carrier for the resolved fields; they are combinational and
   // only the capture cycle takes them into registers
   node_cfg_if cfg ();

   // live resolver: switch split and stored-value fallback,
   // evaluated every cycle from the current pin levels
   node_cfg_decode u_dec (
      .sw_bits  (sw_bits),
      .nvm_addr (nvm_addr),
      .nvm_rate (nvm_rate),
      .cfg      (cfg.dec)
   );

   // sequencer group
   cap_state_t          state_q;
   cap_state_t          state_d;
   logic [SETTLE_W-1:0] cnt_q;
   logic [SETTLE_W-1:0] cnt_d;
   logic                cap_go;

   // captured configuration group
   logic                valid_q;
   logic                valid_d;
   logic [ADDR_W-1:0]   addr_q;
   logic [ADDR_W-1:0]   addr_d;
   logic [RATE_W-1:0]   rate_q;
   logic [RATE_W-1:0]   rate_d;
   logic [16:0]         div_q;
   logic [16:0]         div_d;

   // port personality group
   logic                mode_q;
   logic                mode_d;
   logic [16:0]         act_q;
   logic [16:0]         act_d;

   // timeline after reset release, with N = SETTLE_CYCLES:
   //   edges 1 to N: counter runs, captured configuration outputs keep their reset values
   //   edge N+1: fields sampled, cfg_valid rises
   //   later edges: fields frozen, switch and stored-value moves ignored
   //   reset again: sequence restarts from edge 1
   // the settle delay lets switch contacts stop bouncing before the sample
   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      cap_go  = 1'b0;
      case (state_q)
         S_SETTLE: begin
            if (cnt_q == SETTLE_W'(SETTLE_CYCLES - 1)) begin
               state_d = S_CAPTURE;
            end else begin
               cnt_d = cnt_q + SETTLE_W'(1);
            end
         end
         S_CAPTURE: begin
            cap_go  = 1'b1;           // RL8
            state_d = S_HOLD;
         end
         S_HOLD: begin
            state_d = S_HOLD;         // RL8
         end
         default: begin
            state_d = S_SETTLE;
            cnt_d   = '0;
         end
      endcase
   end

   // sequencer registers; reset restarts the settle count
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q <= S_SETTLE;
         cnt_q   <= '0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
      end
   end

   // one-shot sample of the resolved fields; cap_go is high for
   // exactly one cycle per reset, so the fields never move again
   // until the next reset
   always_comb begin
      valid_d = valid_q;
      addr_d  = addr_q;
      rate_d  = rate_q;
      div_d   = div_q;
      if (cap_go) begin
         valid_d = 1'b1;
         addr_d  = cfg.addr;       // RL8
         rate_d  = cfg.rate;       // RL8
         div_d   = cfg.rate_div;   // RL6
      end
   end

   // captured configuration registers; reset shows address 0, rate 0
   // and the slowest divider until the capture edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         valid_q <= 1'b0;
         addr_q  <= ADDR_FROM_NVM;
         rate_q  <= RATE_FROM_NVM;
         div_q   <= DIV_9K6;
      end else begin
         valid_q <= valid_d;
         addr_q  <= addr_d;
         rate_q  <= rate_d;
         div_q   <= div_d;
      end
   end

   // personality: switch-derived rate only reaches the rs-485 path,
   // the rs-232 divider passes through untouched whatever the switches
   // say; before capture the rs-485 path shows the slowest divider
   always_comb begin
      mode_d = ~sel_pin;                        // RL7
      act_d  = mode_d ? div_q : rs232_div_in;   // RL3
   end

   // personality registers; mode and divider share one stage so that
   // they change on the same edge
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_q <= 1'b0;
         act_q  <= '0;
      end else begin
         mode_q <= mode_d;
         act_q  <= act_d;
      end
   end

   // outputs are plain register copies, no logic after the flops
   // captured configuration to the pins
   assign cfg_valid  = valid_q;
   assign node_addr  = addr_q;
   assign rate_code  = rate_q;
   assign rate_div   = div_q;

   // port personality to the pins
   assign rs485_mode = mode_q;
   assign active_div = act_q;
endmodule

// ==== verification/host_link.sv ====
/* far-side stand-in: drives the port select pin and a restless rs-232 divider
   assumes the bench requests rs-485 through want_485 */
`timescale 1ns/100ps
module host_link(
   input  wire logic        clk,
   input  wire logic        want_485,
   output logic             sel_pin = 1'b1,
   output logic [16:0]      div232 = 17'h00000
);
   // ground the select for rs-485, new divider every cycle
   always @(negedge clk) begin
      sel_pin <= !want_485;
      div232 <= 17'($urandom);
   end
endmodule

// ==== verification/node_cfg_props.sv ====
/* checker for the node configuration selector ports
   assumes one clock domain and an asynchronous active-low reset */
`timescale 1ns/100ps
module node_cfg_props
   import node_cfg_pkg::*;
#(
   parameter int unsigned SETTLE_CYCLES = 2
)(
   input wire logic              clk,
   input wire logic              rst_n,
   input wire logic              sel_pin,
   input wire logic              cfg_valid,
   input wire logic              rs485_mode,
   input wire logic [SW_W-1:0]   sw_bits,
   input wire logic [ADDR_W-1:0] nvm_addr,
   input wire logic [ADDR_W-1:0] node_addr,
   input wire logic [RATE_W-1:0] nvm_rate,
   input wire logic [RATE_W-1:0] rate_code,
   input wire logic [16:0]       rs232_div_in,
   input wire logic [16:0]       rate_div,
   input wire logic [16:0]       active_div
);
   logic [7:0] cnt_q;
   logic [7:0] cnt_d;
   // edges since reset release, saturating
   assign cnt_d = (cnt_q == 8'hFF) ? cnt_q : cnt_q + 8'h01;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_q <= 8'h00;
      end else begin
         cnt_q <= cnt_d;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_ADDR_SW: assert property ($rose(cfg_valid) && $past(sw_bits[5:0]) != 6'h00
      |-> node_addr == $past(sw_bits[5:0])) else $error("address not from switches");
   AST_ADDR_NVM: assert property ($rose(cfg_valid) && $past(sw_bits[5:0]) == 6'h00
      |-> node_addr == $past(nvm_addr)) else $error("stored address not used");
   AST_RATE_SW: assert property ($rose(cfg_valid) && $past(sw_bits[7:6]) != 2'h0
      |-> rate_code == $past(sw_bits[7:6])) else $error("rate not from switches");
   AST_RATE_NVM: assert property ($rose(cfg_valid) && $past(sw_bits[7:6]) == 2'h0
      |-> rate_code == $past(nvm_rate)) else $error("stored rate not used");
   AST_DIV: assert property (cfg_valid |-> rate_div == (rate_code == 2'h2 ? 17'h01458 :
      rate_code == 2'h3 ? 17'h006C8 : 17'h05161)) else $error("bad rate divider");
   AST_HOLD: assert property (cfg_valid |=> cfg_valid && $stable(node_addr)
      && $stable(rate_code)) else $error("capture not held");
   AST_WHEN: assert property ($rose(cfg_valid) |-> cnt_q == SETTLE_CYCLES + 1)
      else $error("capture at wrong edge");
   AST_MODE: assert property ($past(rst_n) |-> rs485_mode == !$past(sel_pin))
      else $error("port mode wrong");
   AST_ACT: assert property ($past(rst_n) |-> active_div == ($past(sel_pin) ?
      $past(rs232_div_in) : $past(rate_div))) else $error("active divider wrong");
   cover property ($rose(cfg_valid) && $past(sw_bits[5:0]) == 6'h00);
   cover property (cfg_valid && rate_code == 2'h3);
   cover property ($rose(rs485_mode));
   cover property ($rose(cfg_valid) && $past(sw_bits[7:6]) == 2'h0 && $past(nvm_rate) == 2'h0);
endmodule
bind serial_node_config_select node_cfg_props #(.SETTLE_CYCLES(SETTLE_CYCLES)) u_props(.*);

// ==== verification/serial_node_config_select_tb.sv ====
/* self-checking bench: eight resets with random switches, then port selection
   assumes a settle count of 2 and the host_link far-side model */
`timescale 1ns/100ps
module serial_node_config_select_tb;
   import node_cfg_pkg::*;
   logic clk = 0, rst_n = 0, want_485 = 0, sel_pin, vld, m485;
   logic [7:0] sw = 8'h00;
   logic [5:0] na = 6'h00, addr;
   logic [1:0] nr = 2'h0, rc;
   logic [16:0] d232, div, adiv;
   int err_count = 0, checked = 0, ea, er, k;
   int exp_q[$];
   initial forever #2.5 clk = ~clk;
   host_link hl(.clk(clk), .want_485(want_485), .sel_pin(sel_pin), .div232(d232));
   serial_node_config_select #(.SETTLE_CYCLES(2)) dut(.clk(clk), .rst_n(rst_n),
      .sw_bits(sw), .nvm_addr(na), .nvm_rate(nr), .sel_pin(sel_pin), .rs232_div_in(d232),
      .cfg_valid(vld), .node_addr(addr), .rate_code(rc), .rate_div(div),
      .rs485_mode(m485), .active_div(adiv));
   // compare and count
   task chk(logic [16:0] s, logic [16:0] e);
      checked++;
      if (s !== e) begin
         err_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   task end_of_test;
      if (err_count == 0 && checked > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // bench model of the rate divider
   function logic [16:0] div_of(int c);
      return c == 2 ? 17'h01458 : c == 3 ? 17'h006C8 : 17'h05161;
   endfunction
   // each pass resets, captures, then ignores later switch moves
   initial begin
      void'($urandom(32'h4021CC85));
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         rst_n = 0;
         sw = 8'($urandom);
         na = 6'($urandom);
         nr = (i == 4) ? 2'h0 : 2'($urandom);
         if (i % 4 == 0) sw[5:0] = 6'h00;
         sw[7:6] = 2'(i);
         repeat (5) @(negedge clk);
         rst_n = 1;
         ea = (sw[5:0] != 0) ? sw[5:0] : na;
         er = (sw[7:6] != 0) ? sw[7:6] : nr;
         exp_q.push_back(ea);
         exp_q.push_back(er);
         k = 0;
         while (vld !== 1'b1 && k < 20) begin
            @(negedge clk);
            k++;
         end
         if (vld !== 1'b1) begin
            err_count++;
            break;
         end
         chk(17'(k), 17'h00003);
         chk(17'(addr), 17'(exp_q.pop_front()));
         chk(17'(rc), 17'(exp_q.pop_front()));
         chk(div, div_of(er));
         for (int j = 0; j < 4; j++) begin
            want_485 = 1'($urandom);
            sw = 8'($urandom);
            na = 6'($urandom);
            nr = 2'($urandom);
            repeat (2) @(negedge clk);
            chk(17'(m485), 17'(want_485));
            chk(adiv, want_485 ? div_of(er) : d232);
            chk(17'(addr), 17'(ea));
            chk(17'(rc), 17'(er));
            chk(div, div_of(er));
         end
      end
      end_of_test;
   end
endmodule
